// >>> verif/igf_switch_model.sv
// far-end model: takes master slices, checks idle fill, keeps flywheels synced
`timescale 1ns/1ps
module igf_switch_model
   import igf_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              rst_n,
   input  wire logic [PRIO_W-1:0] lastPrio,
   input  wire logic              byteValid,
   input  wire logic [IDX_W-1:0]  byteIndex,
   input  wire logic              pktIdle,
   input  wire logic [7:0]        txHi,
   input  wire logic              txKHi,
   input  wire logic [7:0]        txLo,
   input  wire logic              txKLo,
   output logic                   done,
   output logic                   idle,
   output logic                   fillOk,
   output logic                   syncOk,
   output logic      [7:0]        qHi,
   output logic      [7:0]        qLo,
   output logic      [7:0]        one,
   output logic      [7:0]        two,
   output logic      [7:0]        side,
   output logic      [7:0]        extra
);
   logic [TYPE_W-1:0] swType;
   logic [PRIO_W-1:0] swPrio;
   logic              locked;
   wire  [TYPE_W-1:0] rxType   = {qHi[7:6], qHi[0]};
   wire  [PRIO_W-1:0] rxPrio   = qLo[7:6];
   wire  [TYPE_W-1:0] baseType = idle ? rxType : swType;
   wire  [PRIO_W-1:0] basePrio = idle ? rxPrio : swPrio;
   wire               wrap     = basePrio == lastPrio;
   wire  [17:0]       pair     = {txKHi, txHi, txKLo, txLo};
   wire               isFill   = byteIndex > 2 && byteIndex != 5 && byteIndex != 6;
   wire               fillBad  = pktIdle && (byteIndex == 7
                                 ? pair != {1'b1, CODE_K28_1, 1'b1, CODE_K28_5}
                                 : isFill && pair != {1'b0, CODE_D21_5, 1'b0, CODE_D21_5});
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         {done, idle, locked, qHi, qLo, one, two, side, extra} <= '0;
         fillOk <= 1'b1;
         syncOk <= 1'b1;
         swType <= TYPE_RESET;
         swPrio <= PRIO_RESET;
      end else begin
         done <= byteValid && byteIndex == 4'(SLICE_LEN - 1);
         if (byteValid && fillBad) fillOk <= 1'b0;
         if (byteValid) begin
            case (byteIndex)
               4'h0: begin
                  qHi <= txHi;
                  qLo <= txLo;
                  idle <= pktIdle;
                  fillOk <= 1'b1;
               end
               4'h1: one <= txHi;
               4'h2: two <= txHi;
               4'h5: side <= txHi;
               4'h6: extra <= txHi;
               4'h9: begin
                  // a slip of our own flywheels shows as a mismatch at the next idle
                  syncOk <= !(idle && locked) || {rxType, rxPrio} == {swType, swPrio};
                  locked <= locked | idle;
                  swPrio <= wrap ? PRIO_RESET : basePrio + 1'b1;
                  swType <= !wrap ? baseType
                            : baseType == TYPE_MCAST ? TYPE_RESET : baseType + 1'b1;
               end
               default: ;
            endcase
         end
      end
   end
endmodule

// >>> verif/ingress_grant_flywheel_parser_test.sv
// self-checking bench for the ingress packet builder
`timescale 1ns/1ps
module ingress_grant_flywheel_parser_test;
   import igf_pkg::*;
   typedef struct packed {logic idle; logic [7:0] qh, ql, one, two, side, extra;} igf_exp_type;
   logic mclk = 0, rst_n = 0, headerLen3 = 0, pktReq = 0, extBitmapHi = 0, extBitmapLo = 0;
   logic bestEffortHi = 0, bestEffortLo = 0;
   logic [1:0] lastPrio = 3, color = 0, protectionHi = 0, protectionLo = 0;
   logic [1:0] pktPrioHi = 0, pktPrioLo = 0, fwPrio, fp;
   logic [2:0] fwSubType, ft;
   logic [3:0] sideNibble = 0, mcGrant = 0, sendGrant = 0, byteIndex;
   logic [15:0] oqGrant = 0, seed = 16'h0029;
   logic [7:0] bitmapOneHi = 0, bitmapTwoHi = 0, bitmapOneLo = 0, bitmapTwoLo = 0;
   logic [7:0] payloadHi = 0, payloadLo = 0, txHi, txLo, swQHi, swQLo, swOne, swTwo;
   logic [7:0] swSide, swExtra, slaveHi;
   logic byteValid, pktIdle, txKHi, txKLo, swDone, swIdle, swFill, swSync;
   logic pktTaken, payloadTake, tk = 0;
   int num_errors = 0, checks_done = 0;
   igf_exp_type expQ[$];
   igf_exp_type e;
   always #2 mclk = ~mclk;
   igf_ingress_builder dut (.mclk(mclk), .rst_n(rst_n), .lastPrio(lastPrio),
      .headerLen3(headerLen3), .color(color), .sideNibble(sideNibble), .oqGrant(oqGrant),
      .mcGrant(mcGrant), .sendGrant(sendGrant), .pktReq(pktReq), .extBitmapHi(extBitmapHi),
      .extBitmapLo(extBitmapLo), .protectionHi(protectionHi), .protectionLo(protectionLo),
      .bestEffortHi(bestEffortHi), .bestEffortLo(bestEffortLo), .pktPrioHi(pktPrioHi),
      .pktPrioLo(pktPrioLo), .bitmapOneHi(bitmapOneHi), .bitmapTwoHi(bitmapTwoHi),
      .bitmapOneLo(bitmapOneLo), .bitmapTwoLo(bitmapTwoLo), .payloadHi(payloadHi),
      .payloadLo(payloadLo), .pktTaken(pktTaken), .byteValid(byteValid), .byteIndex(byteIndex),
      .pktIdle(pktIdle), .payloadTake(payloadTake), .txHi(txHi), .txKHi(txKHi), .txLo(txLo),
      .txKLo(txKLo), .slaveHi(slaveHi), .slaveKHi(), .slaveLo(), .slaveKLo(),
      .fwSubType(fwSubType), .fwPrio(fwPrio));
   igf_switch_model far (.mclk(mclk), .rst_n(rst_n), .lastPrio(lastPrio), .byteValid(byteValid),
      .byteIndex(byteIndex), .pktIdle(pktIdle), .txHi(txHi), .txKHi(txKHi), .txLo(txLo),
      .txKLo(txKLo), .done(swDone), .idle(swIdle), .fillOk(swFill), .syncOk(swSync),
      .qHi(swQHi), .qLo(swQLo), .one(swOne), .two(swTwo), .side(swSide), .extra(swExtra));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // parity bit makes the xor over the configured header length come out even
   function automatic logic [7:0] par(input logic [7:0] q, a, b, input logic l3);
      return {q[7:2], ^{q, a} ^ (l3 & ^b), q[0]};
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic nextPkt();
      logic [63:0] r;
      logic        sg;
      logic [7:0]  t2h;
      logic [7:0]  t2l;
      igf_exp_type x;
      check({3'h0, fwSubType, fwPrio}, {3'h0, ft, fp});
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         r = {r[47:0], seed};
      end
      {bitmapOneLo, bitmapOneHi, pktPrioLo, pktPrioHi, bestEffortLo, bestEffortHi, protectionLo,
       protectionHi, extBitmapLo, extBitmapHi, pktReq, headerLen3, color[0], sideNibble,
       sendGrant, mcGrant, oqGrant} = r[58:0];
      {bitmapTwoHi, bitmapTwoLo, payloadHi, payloadLo} = r[63:32];
      sg = ft == TYPE_MCAST ? mcGrant[fp] : oqGrant[{ft[1:0], fp}];
      t2h = headerLen3 ? bitmapTwoHi : payloadHi;
      t2l = headerLen3 ? bitmapTwoLo : payloadLo;
      if (pktReq) begin
         x.qh = par({pktPrioHi, sendGrant[fp], bestEffortHi, protectionHi, 1'b0, extBitmapHi},
                    bitmapOneHi, t2h, headerLen3);
         x.ql = par({pktPrioLo, sg, bestEffortLo, protectionLo, 1'b0, extBitmapLo},
                    bitmapOneLo, t2l, headerLen3);
         x.one = bitmapOneHi;
         x.two = t2h;
      end else begin
         x.one = {oqGrant[11:8], oqGrant[3:0]};
         x.two = {oqGrant[15:12], oqGrant[7:4]};
         x.qh = par({ft[2:1], color, PROT_IDLE, 1'b0, ft[0]}, x.one, x.two, headerLen3);
         x.ql = par({fp, color, PROT_IDLE, 2'b00}, x.one, x.two, headerLen3);
      end
      x.idle = !pktReq;
      x.side = {2{sideNibble}};
      x.extra = {sendGrant, mcGrant};
      expQ.push_back(x);
      if (fp == lastPrio) begin
         fp = PRIO_RESET;
         ft = ft == TYPE_MCAST ? TYPE_RESET : ft + 3'h1;
      end else fp = fp + 2'h1;
   endtask
   // second run after a fresh reset uses two priorities, so the wrap point moves
   task automatic runPhase(input logic [1:0] lp, input int n);
      int k;
      rst_n = 1'b0;
      lastPrio = lp;
      ft = TYPE_RESET;
      fp = PRIO_RESET;
      expQ.delete();
      repeat (6) @(posedge mclk);
      #1 nextPkt();
      rst_n = 1'b1;
      repeat (n) begin
         for (k = 0; k < 60; k++) begin
            @(posedge mclk);
            #1;
            if (byteValid === 1'b1 && byteIndex === 4'h8) break;
         end
         if (k == 60) begin
            num_errors++;
            wrap_up();
         end
         nextPkt();
      end
      repeat (24) @(posedge mclk);
      #1 check(8'(expQ.size()), 8'h00);
      $display("run with last priority %0d done", lp);
   endtask
   always @(posedge mclk) begin
      // a taken pulse must precede byte 0 of every data packet and of no idle one
      tk = rst_n && (tk || pktTaken === 1'b1);
      if (byteValid === 1'b1 && byteIndex === 4'h0) begin
         check({7'h00, tk}, {7'h00, !pktIdle});
         tk = 1'b0;
      end
      if (byteValid === 1'b1 && byteIndex > 4'h2) begin
         check({7'h00, payloadTake}, {7'h00, !pktIdle});
      end
      // payload changes right after byte 8, so data slave bytes 8 and 9 are skipped
      if (byteValid === 1'b1 && (pktIdle === 1'b1 || byteIndex < 4'h8)) begin
         check(slaveHi, !pktIdle ? payloadHi
                        : byteIndex == 4'h7 ? CODE_K28_1 : CODE_D21_5);
      end
      if (rst_n && swDone) begin
         if (expQ.size() == 0) begin
            check(8'h01, 8'h00);
         end else begin
            e = expQ.pop_front();
            check({7'h00, swIdle}, {7'h00, e.idle});
            check(swQHi, e.qh);
            check(swQLo, e.ql);
            check(swOne, e.one);
            check(swTwo, e.two);
            if (e.idle) begin
               check(swSide, e.side);
               check(swExtra, e.extra);
               check({6'h00, swFill, swSync}, 8'h03);
            end
         end
      end
   end
   initial begin
      #1;
      runPhase(2'h3, 26);
      runPhase(2'h1, 12);
      wrap_up();
   end
endmodule

// >>> verilog/igf_flywheel.sv
// subport-type and grant-priority flywheels of one ingress port
`timescale 1ns/1ps
module igf_flywheel
   import igf_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              rst_n,
   input  wire logic              advance,
   input  wire logic [PRIO_W-1:0] lastPrio,
   output logic      [TYPE_W-1:0] subType,
   output logic      [PRIO_W-1:0] prio
);
   wire              prioWrap      = advance && (prio == lastPrio);
   wire [PRIO_W-1:0] next_prio     = prioWrap ? PRIO_RESET : prio + 2'h1;
   wire [TYPE_W-1:0] next_subType  = (subType == TYPE_MCAST) ? TYPE_RESET
                                                            : subType + 3'h1;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prio    <= PRIO_RESET;
         subType <= TYPE_RESET;
      end else if (advance) begin
         prio <= next_prio;
         if (prioWrap) begin
            subType <= next_subType;
         end
      end
   end

   sequence seqPrioWrap;
      advance && (prio == lastPrio);
   endsequence
   sequence seqPrioStep;
      advance && (prio != lastPrio);
   endsequence

   prioWrap_a: assert property (@(posedge mclk) disable iff (!rst_n)
      seqPrioWrap |=> prio == PRIO_RESET) else $error("priority flywheel did not wrap");
   prioStep_a: assert property (@(posedge mclk) disable iff (!rst_n)
      seqPrioStep |=> prio == $past(prio) + 2'h1 && $stable(subType))
      else $error("priority flywheel step wrong");
   typeStep_a: assert property (@(posedge mclk) disable iff (!rst_n)
      seqPrioWrap ##0 (subType != TYPE_MCAST) |=> subType == $past(subType) + 3'h1)
      else $error("subport-type flywheel step wrong");
   typeWrap_a: assert property (@(posedge mclk) disable iff (!rst_n)
      seqPrioWrap ##0 (subType == TYPE_MCAST) |=> subType == TYPE_RESET)
      else $error("subport-type flywheel did not wrap");
   typeRange_a: assert property (@(posedge mclk) disable iff (!rst_n)
      subType <= TYPE_MCAST) else $error("subport-type flywheel out of range");
   holdStill_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !advance |=> $stable(prio) && $stable(subType)) else $error("flywheel moved idle");
endmodule

// >>> verilog/igf_ingress_builder.sv
// ingress packet builder: grant flywheels, idle and data master slices on two channels
`timescale 1ns/1ps
module igf_ingress_builder
   import igf_pkg::*;
#(
   parameter int SLICE_BYTES = SLICE_LEN
)(
   input  wire logic                   mclk,
   input  wire logic                   rst_n,
   input  wire logic [PRIO_W-1:0]      lastPrio,
   input  wire logic                   headerLen3,
   input  wire logic [1:0]             color,
   input  wire logic [3:0]             sideNibble,
   input  wire logic [15:0]            oqGrant,
   input  wire logic [3:0]             mcGrant,
   input  wire logic [3:0]             sendGrant,
   input  wire logic                   pktReq,
   input  wire logic                   extBitmapHi,
   input  wire logic                   extBitmapLo,
   input  wire logic [1:0]             protectionHi,
   input  wire logic [1:0]             protectionLo,
   input  wire logic                   bestEffortHi,
   input  wire logic                   bestEffortLo,
   input  wire logic [1:0]             pktPrioHi,
   input  wire logic [1:0]             pktPrioLo,
   input  wire logic [7:0]             bitmapOneHi,
   input  wire logic [7:0]             bitmapTwoHi,
   input  wire logic [7:0]             bitmapOneLo,
   input  wire logic [7:0]             bitmapTwoLo,
   input  wire logic [7:0]             payloadHi,
   input  wire logic [7:0]             payloadLo,
   output logic                        pktTaken,
   output logic                        byteValid,
   output logic      [IDX_W-1:0]       byteIndex,
   output logic                        pktIdle,
   output logic                        payloadTake,
   output logic      [7:0]             txHi,
   output logic                        txKHi,
   output logic      [7:0]             txLo,
   output logic                        txKLo,
   output logic      [7:0]             slaveHi,
   output logic                        slaveKHi,
   output logic      [7:0]             slaveLo,
   output logic                        slaveKLo,
   output logic      [TYPE_W-1:0]      fwSubType,
   output logic      [PRIO_W-1:0]      fwPrio
);
   typedef enum logic [1:0] {
      ST_PRIME  = 2'h0,
      ST_STREAM = 2'h1
   } igf_state_type;

   igf_state_type    state;
   logic [DIV_W-1:0] divCnt;
   logic [IDX_W-1:0] idx;
   logic             curIdle;
   logic             curLen3;
   logic [7:0]       qualHi;
   logic [7:0]       qualLo;
   logic [7:0]       oneHi;
   logic [7:0]       oneLo;
   logic [7:0]       twoHi;
   logic [7:0]       twoLo;
   logic [7:0]       sideByte;
   logic [7:0]       extraByte;
   logic [7:0]       nextQualHi;
   logic [7:0]       nextQualLo;

   // returns {control flag, byte} for one position of a master slice
   function automatic logic [8:0] masterByte(
      input logic [IDX_W-1:0] pos,
      input logic             idle,
      input logic             len3,
      input logic [7:0]       q,
      input logic [7:0]       one,
      input logic [7:0]       two,
      input logic [7:0]       side,
      input logic [7:0]       extra,
      input logic [7:0]       pay,
      input logic [7:0]       comma
   );
      logic [8:0] r;
      r = {1'b0, idle ? CODE_D21_5 : pay};
      if (pos == IDX_W'(BYTE_QUAL)) begin
         r = {1'b0, q};
      end else if (pos == IDX_W'(BYTE_ONE)) begin
         r = {1'b0, one};
      end else if (pos == IDX_W'(BYTE_TWO) && (idle || len3)) begin
         r = {1'b0, two};
      end else if (idle && pos == IDX_W'(BYTE_SIDE)) begin
         r = {1'b0, side};
      end else if (idle && pos == IDX_W'(BYTE_EXTRA)) begin
         r = {1'b0, extra};
      end else if (idle && pos == IDX_W'(BYTE_COMMA)) begin
         r = {1'b1, comma};
      end
      return r;
   endfunction

   // one byte per channel every other clock: channels run at half the clock rate
   wire byteEn   = divCnt == DIV_W'(BYTE_CYCLES - 1);
   wire lastByte = idx == IDX_W'(SLICE_BYTES - 1);
   wire loadPkt  = byteEn && (state == ST_PRIME || lastByte);
   // no request at a packet boundary means the link must still carry an idle packet
   wire takeData = loadPkt && pktReq;
   wire emit     = byteEn && state == ST_STREAM;

   // grants picked by the flywheels for data and control headers
   wire [3:0] typeGrants = (fwSubType == TYPE_MCAST) ? mcGrant
                         : oqGrant[4 * fwSubType[1:0] +: NUM_PRIO];
   wire       subSel     = typeGrants[fwPrio];
   wire       sendSel    = sendGrant[fwPrio];

   // idle headers carry the full grant set, flywheels pick none of those grants
   wire [7:0] idleOne    = {oqGrant[11:8], oqGrant[3:0]};
   wire [7:0] idleTwo    = {oqGrant[15:12], oqGrant[7:4]};
   wire [7:0] idleExtra  = {sendGrant, mcGrant};
   wire [7:0] idleSide   = {sideNibble, sideNibble};
   wire [7:0] loadOneHi  = pktReq ? bitmapOneHi : idleOne;
   wire [7:0] loadTwoHi  = pktReq ? bitmapTwoHi : idleTwo;
   wire [7:0] loadOneLo  = pktReq ? bitmapOneLo : idleOne;
   wire [7:0] loadTwoLo  = pktReq ? bitmapTwoLo : idleTwo;

   wire [8:0] selHi = masterByte(idx, curIdle, curLen3, qualHi, oneHi, twoHi,
                                 sideByte, extraByte, payloadHi, CODE_K28_1);
   wire [8:0] selLo = masterByte(idx, curIdle, curLen3, qualLo, oneLo, twoLo,
                                 sideByte, extraByte, payloadLo, CODE_K28_5);
   wire       isComma   = idx == IDX_W'(BYTE_COMMA);
   wire       hdrEnd    = idx > IDX_W'(curLen3 ? BYTE_TWO : BYTE_ONE);
   wire       usesPay   = !curIdle && hdrEnd;

   igf_flywheel u_flywheel (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .advance  (loadPkt),
      .lastPrio (lastPrio),
      .subType  (fwSubType),
      .prio     (fwPrio)
   );

   igf_qual_builder u_qual_hi (
      .isIdle     (!pktReq),
      .lowChan    (1'b0),
      .headerLen3 (headerLen3),
      .subType    (fwSubType),
      .prio       (fwPrio),
      .color      (color),
      .extBitmap  (extBitmapHi),
      .protection (protectionHi),
      .bestEffort (bestEffortHi),
      .pktPrio    (pktPrioHi),
      .grantBit   (sendSel),
      .hdrOne     (loadOneHi),
      .hdrTwo     (loadTwoHi),
      .qual       (nextQualHi)
   );

   igf_qual_builder u_qual_lo (
      .isIdle     (!pktReq),
      .lowChan    (1'b1),
      .headerLen3 (headerLen3),
      .subType    (fwSubType),
      .prio       (fwPrio),
      .color      (color),
      .extBitmap  (extBitmapLo),
      .protection (protectionLo),
      .bestEffort (bestEffortLo),
      .pktPrio    (pktPrioLo),
      .grantBit   (subSel),
      .hdrOne     (loadOneLo),
      .hdrTwo     (loadTwoLo),
      .qual       (nextQualLo)
   );

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         divCnt <= '0;
         state  <= ST_PRIME;
         idx    <= '0;
      end else begin
         divCnt <= byteEn ? '0 : divCnt + DIV_W'(1);
         if (loadPkt) begin
            state <= ST_STREAM;
            idx   <= '0;
         end else if (emit) begin
            idx <= idx + IDX_W'(1);
         end
      end
   end

   // header of the next packet is latched while the last byte of this one goes out
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         curIdle   <= 1'b1;
         curLen3   <= 1'b0;
         qualHi    <= 8'h00;
         qualLo    <= 8'h00;
         oneHi     <= 8'h00;
         oneLo     <= 8'h00;
         twoHi     <= 8'h00;
         twoLo     <= 8'h00;
         sideByte  <= 8'h00;
         extraByte <= 8'h00;
      end else if (loadPkt) begin
         curIdle   <= !pktReq;
         curLen3   <= headerLen3;
         qualHi    <= nextQualHi;
         qualLo    <= nextQualLo;
         oneHi     <= loadOneHi;
         oneLo     <= loadOneLo;
         twoHi     <= loadTwoHi;
         twoLo     <= loadTwoLo;
         sideByte  <= idleSide;
         extraByte <= idleExtra;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pktTaken    <= 1'b0;
         byteValid   <= 1'b0;
         byteIndex   <= '0;
         pktIdle     <= 1'b1;
         payloadTake <= 1'b0;
         txHi        <= 8'h00;
         txKHi       <= 1'b0;
         txLo        <= 8'h00;
         txKLo       <= 1'b0;
         slaveHi     <= 8'h00;
         slaveKHi    <= 1'b0;
         slaveLo     <= 8'h00;
         slaveKLo    <= 1'b0;
      end else begin
         pktTaken    <= takeData;
         byteValid   <= emit;
         payloadTake <= emit && usesPay;
         if (emit) begin
            byteIndex <= idx;
            pktIdle   <= curIdle;
            {txKHi, txHi} <= selHi;
            {txKLo, txLo} <= selLo;
            // slave slices of an idle packet repeat the fill and comma pattern
            {slaveKHi, slaveHi} <= !curIdle ? {1'b0, payloadHi}
                                 : isComma  ? {1'b1, CODE_K28_1} : {1'b0, CODE_D21_5};
            {slaveKLo, slaveLo} <= !curIdle ? {1'b0, payloadLo}
                                 : isComma  ? {1'b1, CODE_K28_5} : {1'b0, CODE_D21_5};
         end
      end
   end

   wire hdrParHi = oddParity(qualHi) ^ oddParity(oneHi) ^ (curLen3 & oddParity(twoHi));
   wire hdrParLo = oddParity(qualLo) ^ oddParity(oneLo) ^ (curLen3 & oddParity(twoLo));

   sequence seqIdleLoad;
      loadPkt && !pktReq;
   endsequence

   headerParity_a: assert property (@(posedge mclk) disable iff (!rst_n)
      loadPkt |=> !hdrParHi && !hdrParLo) else $error("header parity wrong");
   idleProtect_a: assert property (@(posedge mclk) disable iff (!rst_n)
      seqIdleLoad |=> curIdle && qualHi[3:2] == PROT_IDLE && qualLo[3:2] == PROT_IDLE)
      else $error("idle protection field not zero");
   idleStatus_a: assert property (@(posedge mclk) disable iff (!rst_n)
      seqIdleLoad |=> {qualHi[7:6], qualHi[0]} == $past(fwSubType)
                      && qualLo[7:6] == $past(fwPrio) && !qualLo[0])
      else $error("idle flywheel status wrong");
   idleColor_a: assert property (@(posedge mclk) disable iff (!rst_n)
      seqIdleLoad |=> qualHi[5:4] == $past(color) && qualLo[5:4] == $past(color))
      else $error("idle color wrong");
   dataGrant_a: assert property (@(posedge mclk) disable iff (!rst_n)
      takeData |=> qualHi[Q_GRANT] == $past(sendSel) && qualLo[Q_GRANT] == $past(subSel))
      else $error("data qualifier grant wrong");
   sideCopy_a: assert property (@(posedge mclk) disable iff (!rst_n)
      byteValid && pktIdle && byteIndex == IDX_W'(BYTE_SIDE)
      |-> txHi[7:4] == txHi[3:0] && txLo == txHi) else $error("side byte not duplicated");
   idleComma_a: assert property (@(posedge mclk) disable iff (!rst_n)
      byteValid && pktIdle && byteIndex == IDX_W'(BYTE_COMMA)
      |-> txKHi && txHi == CODE_K28_1 && txKLo && txLo == CODE_K28_5 && slaveKLo)
      else $error("idle comma byte wrong");
   flyAdvance_a: assert property (@(posedge mclk) disable iff (!rst_n)
      seqIdleLoad ##0 (fwPrio != lastPrio) |=> fwPrio == $past(fwPrio) + 2'h1)
      else $error("flywheel stalled on idle packet");
   pktSpacing_a: assert property (@(posedge mclk) disable iff (!rst_n)
      loadPkt |=> !loadPkt [*8]) else $error("packet cycles too close");
endmodule

// >>> verilog/igf_pkg.sv
// constants and helpers for the ingress grant flywheel packet builder
// Behaviour
// - each data or control header carries one subport grant and one send grant
// - idle packets skip flywheel selection and carry all 20 subport and 4 send grants
// - both flywheels keep advancing in packet cycles that carry idle packets
// - subport-type flywheel steps 000 to 011 for subports 0-3, then 100 for multicast
// - carried subport grant is picked by subport type together with grant priority
// - subport-type flywheel advances each time the priority flywheel wraps to zero
// - priority flywheel codes priorities 0-3 and picks both send and subport grant
// - priority flywheel advances every packet cycle, wrapping after the enabled count
// - four priorities give 20-cycle subport refresh and 4-cycle send refresh
// - idle qualifier byte carries our current flywheel status for far-end sync
// - subport grants go in idle bytes one, two, six and data qualifier byte
// - idle slice fill is D21.5, byte 7 K28.1 high and K28.5 low
// - side-channel byte carries a nibble in bits 0:3 copied into bits 4:7
// - high idle qualifier holds subport type in bit 0 and bits 6:7
// - low idle qualifier leaves bit 0 reserved, priority status in bits 6:7
// - idle qualifier sets bit 1 to parity and protection bits 2:3 to 00
// - idle qualifier bits 4:5 carry color, 00 blue, 01 red
// - idle byte one holds subports 0 and 2, byte two subports 1 and 3
// - extra grant byte holds multicast grants low nibble, send grants high nibble
// - a grant bit of one means active, zero inactive
// - header parity bit covers every header byte of configured length
// - data qualifier bit 5 is send grant high channel, subport grant low channel
package igf_pkg;
   localparam int          CLK_PERIOD_NS  = 4;
   localparam int          BYTE_PERIOD_NS = 8;
   localparam int          BYTE_CYCLES    = BYTE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int          DIV_W          = 1;
   localparam int          SLICE_LEN      = 10;
   localparam int          IDX_W          = 4;
   localparam int          TYPE_W         = 3;
   localparam int          PRIO_W         = 2;
   localparam int          NUM_SUBPORTS   = 4;
   localparam int          NUM_PRIO       = 4;
   localparam int          BYTE_QUAL      = 0;
   localparam int          BYTE_ONE       = 1;
   localparam int          BYTE_TWO       = 2;
   localparam int          BYTE_SIDE      = 5;
   localparam int          BYTE_EXTRA     = 6;
   localparam int          BYTE_COMMA     = 7;
   localparam int          Q_EXT          = 0;
   localparam int          Q_PAR          = 1;
   localparam int          Q_GRANT        = 5;
   localparam logic [7:0]  CODE_D21_5     = 8'hB5;
   localparam logic [7:0]  CODE_K28_1     = 8'h3C;
   localparam logic [7:0]  CODE_K28_5     = 8'hBC;
   localparam logic [1:0]  PROT_IDLE      = 2'h0;
   localparam logic [2:0]  TYPE_MCAST     = 3'h4;
   localparam logic [2:0]  TYPE_RESET     = 3'h0;
   localparam logic [1:0]  PRIO_RESET     = 2'h0;

   function automatic logic oddParity(input logic [7:0] b);
      return ^b;
   endfunction
endpackage

// >>> verilog/igf_qual_builder.sv
// qualifier byte builder for one channel, idle or data form, with parity
`timescale 1ns/1ps
module igf_qual_builder
   import igf_pkg::*;
(
   input  wire logic              isIdle,
   input  wire logic              lowChan,
   input  wire logic              headerLen3,
   input  wire logic [TYPE_W-1:0] subType,
   input  wire logic [PRIO_W-1:0] prio,
   input  wire logic [1:0]        color,
   input  wire logic              extBitmap,
   input  wire logic [1:0]        protection,
   input  wire logic              bestEffort,
   input  wire logic [1:0]        pktPrio,
   input  wire logic              grantBit,
   input  wire logic [7:0]        hdrOne,
   input  wire logic [7:0]        hdrTwo,
   output logic      [7:0]        qual
);
   wire [1:0] statusTop  = lowChan ? prio : subType[2:1];
   wire       statusLow  = lowChan ? 1'b0 : subType[0];
   wire [7:0] idleBody   = {statusTop, color, PROT_IDLE, 1'b0, statusLow};
   wire [7:0] dataBody   = {pktPrio, grantBit, bestEffort, protection, 1'b0, extBitmap};
   wire [7:0] body       = isIdle ? idleBody : dataBody;
   wire       twoPar     = headerLen3 ? oddParity(hdrTwo) : 1'b0;
   // parity bit is one when the other header bits hold an odd count of ones
   wire       parityBit  = oddParity(body) ^ oddParity(hdrOne) ^ twoPar;

   always_comb begin
      qual        = body;
      qual[Q_PAR] = parityBit;
   end
endmodule
